// ===== hw/move_pkg.sv
`default_nettype none
package move_pkg;
  // Word and field widths of the core
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // Field positions inside the instruction word
  localparam int OP_HI = 13;
  localparam int LIT_OP_LO = 10;
  localparam int COPY_OP_LO = 8;
  localparam int DEST_BIT = 7;
  // Opcode patterns; the two bits below the literal opcode are don't-care
  localparam logic [3:0] LIT_OPCODE = 4'hc;
  localparam logic [5:0] COPY_OPCODE = 6'h08;
  // Reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  // Quarter phases of one instruction cycle
  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;
endpackage
`default_nettype wire

// ===== hw/move_decode.sv
`timescale 1ns/1ns
`default_nettype none
module move_decode
  import move_pkg::*;
(
  input wire logic [move_pkg::INSTR_W-1:0] instr,
  output logic is_literal,
  output logic is_copy,
  output logic dest_self,
  output logic [move_pkg::DATA_W-1:0] literal,
  output logic [move_pkg::ADDR_W-1:0] reg_index
);
  // Bits 9:8 take no part in the literal decode, so any filler value decodes alike
  assign is_literal = (instr[OP_HI:LIT_OP_LO] == LIT_OPCODE); // [RULE_02]
  assign is_copy = (instr[OP_HI:COPY_OP_LO] == COPY_OPCODE); // [RULE_03]
  // Operand fields
  assign dest_self = instr[DEST_BIT];
  assign literal = instr[DATA_W-1:0];
  assign reg_index = instr[ADDR_W-1:0];
endmodule // move_decode
`default_nettype wire

// ===== hw/move_exec.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE_01] Opcode 11 00xx loads the low eight bits into the accumulator; flags untouched.
// [RULE_02] The two don't-care bits of the literal load are ignored.
// [RULE_03] Opcode 00 1000 reads register f; d=0 to accumulator, d=1 back to f.
// [RULE_04] Register copy updates the zero flag for both destinations.
// [RULE_05] Register copy: decode Q1, read Q2, process Q3, write Q4; one cycle.
// [RULE_06] Literal load: one word, decode Q1, read Q2, process Q3, write Q4.
// [RULE_07] Zero flag set when the moved value is zero, else cleared.
module move_exec
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [move_pkg::INSTR_W-1:0] instr,
  input wire logic [move_pkg::DATA_W-1:0] reg_rdata,
  output move_pkg::phase_e phase,
  output logic [move_pkg::ADDR_W-1:0] reg_addr,
  output logic [move_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_we,
  output logic [move_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  output logic zero_we
);
  import move_pkg::*;

  phase_e phase_r;
  phase_e phase_nxt;
  logic lit_r;
  logic copy_r;
  logic self_r;
  logic [DATA_W-1:0] lit_val_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] acc_r;
  logic zero_r;
  logic zero_we_r;
  logic reg_we_r;
  logic dec_lit;
  logic dec_copy;
  logic dec_self;
  logic [DATA_W-1:0] dec_literal;
  logic [ADDR_W-1:0] dec_index;
  logic take;
  logic [DATA_W-1:0] data_nxt;
  logic write_acc;
  logic write_reg;

  // Decode of the word offered during Q1
  move_decode u_decode
  (
    .instr(instr),
    .is_literal(dec_lit),
    .is_copy(dec_copy),
    .dest_self(dec_self),
    .literal(dec_literal),
    .reg_index(dec_index)
  );

  // Quarter phase sequencer; one instruction per four clocks
  always_comb
  begin
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
    endcase
  end

  // Step selection; unknown opcodes pass through as no-operations
  assign take = (phase_r == PH_Q1) && instr_valid;
  assign data_nxt = copy_r ? reg_rdata : lit_val_r; // [RULE_03] [RULE_06]
  assign write_acc = (phase_r == PH_Q3) && (lit_r || (copy_r && !self_r)); // [RULE_01]
  assign write_reg = (phase_r == PH_Q3) && copy_r && self_r; // [RULE_03]

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      phase_r <= PH_Q1;
    else
      phase_r <= phase_nxt;
  end

  // Q1 decode: latch the operation and its operand fields
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lit_r <= 1'b0;
      copy_r <= 1'b0;
      self_r <= 1'b0;
      lit_val_r <= 8'h00;
      addr_r <= 7'h00;
    end
    else if (take)
    begin
      lit_r <= dec_lit; // [RULE_01]
      copy_r <= dec_copy; // [RULE_03]
      self_r <= dec_self;
      lit_val_r <= dec_literal;
      addr_r <= dec_index;
    end
    else if (phase_r == PH_Q1)
    begin
      // Idle slot: no operation this cycle
      lit_r <= 1'b0;
      copy_r <= 1'b0;
    end
  end

  // Q2 read: source register or literal sampled at the end of Q2
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      data_r <= 8'h00;
    else if (phase_r == PH_Q2)
      data_r <= data_nxt; // [RULE_05] [RULE_06]
  end

  // Q3 process: results land so that they stand during Q4
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc_r <= ACC_RESET;
      zero_r <= ZERO_RESET;
      zero_we_r <= 1'b0;
      reg_we_r <= 1'b0;
    end
    else
    begin
      if (write_acc)
        acc_r <= data_r; // [RULE_01] [RULE_03]
      if ((phase_r == PH_Q3) && copy_r)
        zero_r <= (data_r == 8'h00); // [RULE_04] [RULE_07]
      // Literal load never raises the flag strobe
      zero_we_r <= (phase_r == PH_Q3) && copy_r; // [RULE_04]
      reg_we_r <= write_reg; // [RULE_05]
    end
  end

  assign phase = phase_r;
  assign reg_addr = addr_r;
  // Write data is the read value held since Q2, so a self copy is harmless
  assign reg_wdata = data_r;
  assign reg_we = reg_we_r;
  assign acc = acc_r;
  assign zero_flag = zero_r;
  assign zero_we = zero_we_r;

  // Checks on the executed behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  lit_loads_acc_a: assert property ( // [RULE_01]
    take && dec_lit |-> ##3 (acc_r == $past(instr[7:0], 3)) && !reg_we_r)
    else $error("literal not loaded into accumulator");

  lit_dontcare_a: assert property ( // [RULE_02]
    take && (instr[13:10] == 4'hc) |-> ##3 (acc_r == $past(instr[7:0], 3)))
    else $error("literal load depends on filler bits");

  lit_no_flag_a: assert property ( // [RULE_01]
    take && dec_lit |-> ##1 (!zero_we_r && !reg_we_r) [*3])
    else $error("literal load touched flag or register");

  copy_to_acc_a: assert property ( // [RULE_03]
    take && dec_copy && !instr[7] |-> ##3 (acc_r == $past(reg_rdata, 2)) && !reg_we_r)
    else $error("copy to accumulator wrong");

  copy_to_self_a: assert property ( // [RULE_03]
    take && dec_copy && instr[7] |->
      ##3 reg_we_r && (reg_addr == $past(instr[6:0], 3)) && (reg_wdata == $past(reg_rdata, 2)))
    else $error("copy back to register wrong");

  copy_zero_a: assert property ( // [RULE_07]
    take && dec_copy |-> ##3 zero_we_r && (zero_r == ($past(reg_rdata, 2) == 8'h00)))
    else $error("zero flag wrong after copy");

  flag_only_copy_a: assert property ( // [RULE_04]
    zero_we_r |-> $past(copy_r) && (phase_r == PH_Q4))
    else $error("zero strobe without copy");

  write_in_q4_a: assert property ( // [RULE_05]
    reg_we_r |-> (phase_r == PH_Q4) ##1 !reg_we_r && (phase_r == PH_Q1))
    else $error("register write outside Q4");

  acc_in_q4_a: assert property ( // [RULE_06]
    $changed(acc_r) |-> (phase_r == PH_Q4))
    else $error("accumulator changed outside Q4");

  // Flag moves with the write slot only, never mid-instruction
  zero_in_q4_a: assert property ( // [RULE_05]
    $changed(zero_r) |-> (phase_r == PH_Q4))
    else $error("zero flag changed outside Q4");

  lit_keeps_flag_a: assert property ( // [RULE_01]
    take && dec_lit |-> ##1 $stable(zero_r) [*3])
    else $error("literal load changed the zero flag");

  self_keeps_acc_a: assert property ( // [RULE_03]
    take && dec_copy && instr[7] |-> ##1 $stable(acc_r) [*3])
    else $error("copy back to register disturbed accumulator");

  // Address must stand through the read and the write slot
  addr_held_a: assert property ( // [RULE_05]
    take |-> ##2 $stable(addr_r) [*2])
    else $error("register index moved during instruction");

  // Words outside both moves must leave every result alone
  noop_quiet_a: assert property ( // [RULE_01]
    take && !dec_lit && !dec_copy |-> ##1 ($stable(acc_r) && !zero_we_r && !reg_we_r) [*3])
    else $error("unknown opcode had an effect");

  lit_cover_c: cover property (take && dec_lit ##3 phase_r == PH_Q4);
  copy_acc_cover_c: cover property (take && dec_copy && !instr[7] ##3 zero_we_r);
  copy_self_cover_c: cover property (take && dec_copy && instr[7] ##3 reg_we_r && zero_r);
  noop_cover_c: cover property (take && !dec_lit && !dec_copy ##3 phase_r == PH_Q4);
  filler_cover_c: cover property (take && dec_lit && (instr[9:8] == 2'b11));
endmodule // move_exec
`default_nettype wire

// ===== tb/move_bench.sv
`timescale 1ns/1ns
`default_nettype none
module literal_and_register_move_decode_bench;
  import move_pkg::*;
  logic clk;
  logic reset;
  logic instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0] reg_rdata;
  phase_e phase;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_we;
  logic [DATA_W-1:0] acc;
  logic zero_flag;
  logic zero_we;
  logic [DATA_W-1:0] acc_exp;
  int err_total;
  int checked;

  move_exec u_move_exec
  (
    .clk(clk),
    .reset(reset),
    .instr_valid(instr_valid),
    .instr(instr),
    .reg_rdata(reg_rdata),
    .phase(phase),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .acc(acc),
    .zero_flag(zero_flag),
    .zero_we(zero_we)
  );

  // 50 ns core clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Offer a word for the next Q1 only, then stop in the middle of Q4
  task automatic issue(input logic [13:0] word, input logic [7:0] data);
    int n;
    for (n = 0; n < 8 && phase !== PH_Q4; n++)
      @(negedge clk);
    if (n == 8)
    begin
      err_total++;
      results();
    end
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= word;
    reg_rdata <= data;
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(8'(phase), 8'h03);
  endtask

  // All four don't-care patterns, flag must keep its value
  task automatic lit_load(input logic zf);
    logic [7:0] lits [4];
    lits = '{8'h00, 8'h5A, 8'hFF, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      issue({4'b1100, 2'(i), lits[i]}, 8'hA5);
      chk(acc, lits[i]);
      chk(8'(zero_flag), 8'(zf));
      chk(8'({zero_we, reg_we}), 8'h00);
    end
    acc_exp = 8'h01;
  endtask

  // Register copy to either destination, zero flag from moved value
  task automatic copy(input logic d, input logic [6:0] f, input logic [7:0] data);
    issue({6'b001000, d, f}, data);
    if (!d)
      acc_exp = data;
    chk(8'(reg_addr), 8'(f));
    chk(acc, acc_exp);
    chk(8'(reg_we), 8'(d));
    if (d)
      chk(reg_wdata, data);
    chk(8'(zero_flag), 8'(data == 8'h00));
    chk(8'(zero_we), 8'h01);
    @(negedge clk);
    chk(8'({zero_we, reg_we}), 8'h00);
  endtask

  // Near-miss opcodes must leave the accumulator, the zero flag and both strobes alone
  task automatic no_op(input logic zf);
    issue({4'b1101, 2'b00, 8'h3C}, 8'h00);
    chk(acc, acc_exp);
    chk(8'({zero_flag, zero_we, reg_we}), 8'({zf, 2'b00}));
    issue({6'b001001, 1'b1, 7'h11}, 8'h00);
    chk(acc, acc_exp);
    chk(8'({zero_flag, zero_we, reg_we}), 8'({zf, 2'b00}));
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    err_total = 0;
    checked = 0;
    acc_exp = 8'h00;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = 14'h0000;
    reg_rdata = 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    copy(1'b0, 7'h7F, 8'hC3);
    copy(1'b0, 7'h05, 8'h00);
    lit_load(1'b1);
    no_op(1'b1);
    copy(1'b1, 7'h7F, 8'h80);
    copy(1'b1, 7'h00, 8'h00);
    copy(1'b0, 7'h7F, 8'hC3);
    lit_load(1'b0);
    results();
  end
endmodule // literal_and_register_move_decode_bench
`default_nettype wire
